// ### verilog/lpc_pkg.sv
package lpc_pkg;
   // Register addresses (7-bit command space)
   localparam logic [6:0] LPC_ADDR_PORT_FIRST = 7'h00;
   localparam logic [6:0] LPC_ADDR_PORT_LAST  = 7'h09;
   localparam logic [6:0] LPC_ADDR_GRP_ALL    = 7'h0a;
   localparam logic [6:0] LPC_ADDR_GRP_LOW    = 7'h0b;
   localparam logic [6:0] LPC_ADDR_GRP_MID    = 7'h0c;
   localparam logic [6:0] LPC_ADDR_GRP_HIGH   = 7'h0d;
   localparam logic [6:0] LPC_ADDR_IN_LOW     = 7'h0e;
   localparam logic [6:0] LPC_ADDR_IN_HIGH    = 7'h0f;
   localparam logic [6:0] LPC_ADDR_CONFIG     = 7'h10;
   // Configuration bit positions
   localparam int LPC_CFG_RUN     = 0;
   localparam int LPC_CFG_CSRUN   = 1;
   localparam int LPC_CFG_RAMP    = 2;
   localparam int LPC_CFG_FADE    = 3;
   localparam int LPC_CFG_HOLD    = 4;
   localparam int LPC_CFG_STAGGER = 5;
   localparam int LPC_CFG_OSC     = 7;
   // Port codes
   localparam logic [7:0] LPC_CODE_LOW     = 8'h00;
   localparam logic [7:0] LPC_CODE_INPUT   = 8'h01;
   localparam logic [7:0] LPC_CODE_SINK    = 8'h02;
   localparam logic [7:0] LPC_CODE_HIZ     = 8'hff;
   localparam logic [7:0] LPC_PORT_RESET   = 8'hff;
   // PWM timing
   localparam logic [7:0] LPC_STAGGER_STEP = 8'h20;
   localparam logic       LPC_OSC_RESET    = 1'b0;
   typedef enum logic [2:0] {LPC_SHUTDOWN, LPC_RUN, LPC_RAMP, LPC_HOLD, LPC_FADE} lpc_mode_t;
endpackage

// ### verilog/lpc_regs.sv
`timescale 1ns/100ps
// Overview of operation
// - Config write D0=0 enters or keeps shutdown; D1 sets chip-select wake enable.
// - In shutdown with wake enabled, a chip-select pulse brings the device out.
// - From shutdown, D0=1 D2=0 enters run at once.
// - From shutdown, D0=1 D2=1 leaves through a ramp-up sequence.
// - D0=1 during hold-off or fade-off aborts it, back to run at once.
// - Read-back D4 shows hold-off, D3 shows fade-off, both with D0=0.
// - Read-back D2/D0 show shutdown, run, ramp-up; D5 and D1 echo settings.
// - Stagger bit 0 puts PWM in phase, 1 staggers outputs.
// - D7 selects internal oscillator with data out, or external clock input.
// - Clock source reset value depends on device variant.
// - Output code 0x01 makes the port a high-impedance logic input.
// - Input registers show pin level for input ports, zero otherwise.
// - Input registers are read-only; writes are discarded.
// - 0x0E returns ports 7..0; 0x0F returns ports 9,8 in D1,D0.
// - Ten 8-bit output registers at consecutive addresses.
// - Group pseudo-addresses write the same data to all ports of the group.
// - Current sinks are static or PWM between 3 and 254 of 256.
// - Output codes select low, input, sink, PWM duty or high impedance.
// - PWM period is 256 pwm_tick counts; staggered ports offset by 32 counts.
// - Reset gives high-impedance ports, reset values and shutdown.
module lpc_regs
   import lpc_pkg::*;
#(
   parameter int  NUM_PORTS = 10,
   parameter logic OSC_DEFAULT = LPC_OSC_RESET
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 resetn,
   // Register access from the serial front end
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   input  wire logic [6:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   output logic      [7:0]           reg_rdata,
   // Shutdown sequencer
   input  wire logic                 cs_wake_pulse,
   input  wire logic                 shutdown_request,
   input  wire logic                 hold_done,
   input  wire logic                 fade_done,
   input  wire logic                 ramp_done,
   output logic      [2:0]           seq_mode,
   // PWM
   input  wire logic                 pwm_tick,
   output logic                      osc_external,
   // Port pins
   input  wire logic [NUM_PORTS-1:0] port_in,
   output logic      [NUM_PORTS-1:0] port_out,
   output logic      [NUM_PORTS-1:0] port_oe,
   output logic      [NUM_PORTS-1:0] input_enable
);
   initial begin
      if (NUM_PORTS != 10) $error("lpc_regs serves exactly ten ports");
   end

   logic [7:0]           port_code [NUM_PORTS];
   lpc_mode_t            mode;
   lpc_mode_t            next_mode;
   logic                 cs_run;
   logic                 stagger;
   logic [7:0]           pwm_count;
   logic [NUM_PORTS-1:0] in_meta;
   logic [NUM_PORTS-1:0] in_sync;
   logic [1:0]           wake_sync;
   logic                 wake_prev;
   logic                 osc_loaded;
   logic                 cfg_wr;

   assign cfg_wr = reg_wr && reg_addr == LPC_ADDR_CONFIG;

   // Pin levels are asynchronous
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         in_meta   <= '0;
         in_sync   <= '0;
         wake_sync <= 2'b00;
         wake_prev <= 1'b0;
      end else begin
         in_meta   <= port_in;
         in_sync   <= in_meta;
         wake_sync <= {wake_sync[0], cs_wake_pulse};
         wake_prev <= wake_sync[1];
      end
   end

   // Output registers and group writes
   generate
      for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
         logic hit;
         always_comb begin
            hit = 1'b0;
            if (reg_addr == 7'(p))
               hit = 1'b1;
            if (reg_addr == LPC_ADDR_GRP_ALL)
               hit = 1'b1;
            if (reg_addr == LPC_ADDR_GRP_LOW && p < 4)
               hit = 1'b1;
            if (reg_addr == LPC_ADDR_GRP_MID && p >= 4 && p < 8)
               hit = 1'b1;
            if (reg_addr == LPC_ADDR_GRP_HIGH && p >= 8)
               hit = 1'b1;
         end
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn)
               port_code[p] <= LPC_PORT_RESET;
            else if (reg_wr && hit)
               port_code[p] <= reg_wdata;
         end

         logic [7:0] phase;
         logic       active;
         logic       pwm_on;
         logic       sinking;
         assign phase  = stagger ? 8'(pwm_count + 8'(p % 8) * LPC_STAGGER_STEP) : pwm_count;
         assign active = (mode != LPC_SHUTDOWN);
         assign pwm_on = phase < port_code[p];
         always_comb begin
            sinking = 1'b0;
            case (port_code[p])
               LPC_CODE_LOW:   sinking = 1'b1;
               LPC_CODE_INPUT: sinking = 1'b0;
               LPC_CODE_SINK:  sinking = active;
               LPC_CODE_HIZ:   sinking = 1'b0;
               default:        sinking = active && pwm_on;
            endcase
         end
         // Open-drain: drive low only
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               port_oe[p]      <= 1'b0;
               input_enable[p] <= 1'b0;
            end else begin
               port_oe[p]      <= sinking;
               input_enable[p] <= port_code[p] == LPC_CODE_INPUT;
            end
         end
         assign port_out[p] = 1'b0;
      end
   endgenerate

   // PWM counter, 256 ticks per period
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         pwm_count <= 8'h00;
      else if (pwm_tick)
         pwm_count <= pwm_count + 8'h01;
   end

   // Configuration settings
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cs_run       <= 1'b0;
         stagger      <= 1'b0;
         osc_external <= OSC_DEFAULT;
         osc_loaded   <= 1'b0;
      end else begin
         if (!osc_loaded) begin
            osc_external <= OSC_DEFAULT;
            osc_loaded   <= 1'b1;
         end
         if (cfg_wr) begin
            cs_run       <= reg_wdata[LPC_CFG_CSRUN];
            stagger      <= reg_wdata[LPC_CFG_STAGGER];
            osc_external <= reg_wdata[LPC_CFG_OSC];
         end
      end
   end

   // Mode sequencer
   always_comb begin
      next_mode = mode;
      case (mode)
         LPC_SHUTDOWN: begin
            if (cfg_wr && reg_wdata[LPC_CFG_RUN])
               next_mode = reg_wdata[LPC_CFG_RAMP] ? LPC_RAMP : LPC_RUN;
            else if (!cfg_wr && cs_run && wake_sync[1] && !wake_prev)
               next_mode = LPC_RUN;
         end
         LPC_RAMP: begin
            if (cfg_wr && !reg_wdata[LPC_CFG_RUN])
               next_mode = LPC_SHUTDOWN;
            else if (ramp_done)
               next_mode = LPC_RUN;
         end
         LPC_RUN: begin
            if (cfg_wr && !reg_wdata[LPC_CFG_RUN])
               next_mode = LPC_SHUTDOWN;
            else if (shutdown_request)
               next_mode = LPC_HOLD;
         end
         LPC_HOLD, LPC_FADE: begin
            if (cfg_wr && reg_wdata[LPC_CFG_RUN])
               next_mode = LPC_RUN;
            else if (cfg_wr)
               next_mode = LPC_SHUTDOWN;
            else if (mode == LPC_HOLD && hold_done)
               next_mode = LPC_FADE;
            else if (mode == LPC_FADE && fade_done)
               next_mode = LPC_SHUTDOWN;
         end
         default: next_mode = LPC_SHUTDOWN;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         mode <= LPC_SHUTDOWN;
      else
         mode <= next_mode;
   end
   assign seq_mode = 3'(mode);

   // Read data
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= 8'h00;
         if (reg_addr <= LPC_ADDR_PORT_LAST)
            reg_rdata <= port_code[reg_addr[3:0]];
         else if (reg_addr == LPC_ADDR_IN_LOW)
            reg_rdata <= in_sync[7:0] & input_enable[7:0];
         else if (reg_addr == LPC_ADDR_IN_HIGH)
            reg_rdata <= {6'h00, in_sync[9:8] & input_enable[9:8]};
         else if (reg_addr == LPC_ADDR_CONFIG) begin
            reg_rdata[LPC_CFG_OSC]     <= osc_external;
            reg_rdata[LPC_CFG_STAGGER] <= stagger;
            reg_rdata[LPC_CFG_HOLD]    <= mode == LPC_HOLD;
            reg_rdata[LPC_CFG_FADE]    <= mode == LPC_FADE;
            reg_rdata[LPC_CFG_RAMP]    <= mode == LPC_RAMP;
            reg_rdata[LPC_CFG_CSRUN]   <= cs_run;
            reg_rdata[LPC_CFG_RUN]     <= mode == LPC_RUN || mode == LPC_RAMP;
         end
      end
   end
   // Writes to 0x0e/0x0f match no register: discarded

   sequence s_hold_abort;
      mode == LPC_HOLD ##0 cfg_wr ##0 reg_wdata[LPC_CFG_RUN];
   endsequence

   a_abort_to_run: assert property (@(posedge clk) disable iff (!resetn)
      s_hold_abort |=> mode == LPC_RUN) else $error("abort did not return to run");
   a_run_from_sd: assert property (@(posedge clk) disable iff (!resetn)
      mode == LPC_SHUTDOWN && cfg_wr && reg_wdata[0] && !reg_wdata[2] |=> mode == LPC_RUN)
      else $error("instant run not entered");
   a_ramp_from_sd: assert property (@(posedge clk) disable iff (!resetn)
      mode == LPC_SHUTDOWN && cfg_wr && reg_wdata[0] && reg_wdata[2] |=> mode == LPC_RAMP)
      else $error("ramp not entered");
   a_sd_write: assert property (@(posedge clk) disable iff (!resetn)
      cfg_wr && !reg_wdata[0] |=> mode == LPC_SHUTDOWN && cs_run == $past(reg_wdata[1]))
      else $error("shutdown write failed");
   a_wake_pulse: assert property (@(posedge clk) disable iff (!resetn)
      mode == LPC_SHUTDOWN && !cs_run |=> mode != LPC_RUN || $past(cfg_wr))
      else $error("woke without enable");
   a_input_mask: assert property (@(posedge clk) disable iff (!resetn)
      reg_rd && reg_addr == LPC_ADDR_IN_LOW && input_enable[0] == 1'b0 |=> reg_rdata[0] == 1'b0)
      else $error("non-input port read as one");
   a_high_upper: assert property (@(posedge clk) disable iff (!resetn)
      reg_rd && reg_addr == LPC_ADDR_IN_HIGH |=> reg_rdata[7:2] == 6'h00)
      else $error("upper input bits not zero");
   a_status_hold: assert property (@(posedge clk) disable iff (!resetn)
      reg_rd && reg_addr == LPC_ADDR_CONFIG && mode == LPC_HOLD && !cfg_wr
      |=> reg_rdata[4:3] == 2'b10 && !reg_rdata[0])
      else $error("hold-off status wrong");
endmodule

// ### bench/lpc_host_model.sv
`timescale 1ns/100ps
module lpc_host_model (
   // Clock
   input  wire logic       clk,
   // Register bus toward the device
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [6:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 7'h7f;
      reg_wdata = 8'h5a;
   end
   // Stagger only changed in shutdown by the callers
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      // Released lines show garbage, not the last value
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(posedge clk);
      d = reg_rdata;
   endtask
endmodule

// ### bench/test_led_port_config_and_input_regs.sv
`timescale 1ns/100ps
module test_led_port_config_and_input_regs;
   import lpc_pkg::*;
   logic        clk;
   logic        resetn;
   logic        reg_wr;
   logic        reg_rd;
   logic [6:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic        cs_wake;
   logic [3:0]  ev;
   logic        pwm_tick;
   logic        osc_external;
   logic [2:0]  seq_mode;
   logic [9:0]  ext_level;
   logic [9:0]  port_out;
   logic [9:0]  port_oe;
   logic [9:0]  input_enable;
   // Pins at ext_level, pulled low where the device sinks
   wire  [9:0]  pin = (port_oe & port_out) | (~port_oe & ext_level);
   int          fails = 0;
   int          checks_done = 0;
   int          cycles = 0;
   logic [7:0]  v;
   int          n0;
   int          nx;
   logic [7:0]  codes [3] = '{8'h03, 8'h80, 8'hfe};

   lpc_regs uut (.clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cs_wake_pulse(cs_wake), .shutdown_request(ev[0]),
      .hold_done(ev[1]), .fade_done(ev[2]), .ramp_done(ev[3]), .seq_mode(seq_mode), .pwm_tick(pwm_tick),
      .osc_external(osc_external), .port_in(pin), .port_out(port_out), .port_oe(port_oe),
      .input_enable(input_enable));
   lpc_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) pwm_tick <= ~pwm_tick;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails = fails + 1;
         report_and_stop();
      end
   end

   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      checks_done = checks_done + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cfg(input logic [7:0] exp);
      host.rd(LPC_ADDR_CONFIG, v);
      chk("config", {2'b00, exp}, {2'b00, v});
   endtask
   task automatic evp(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
   endtask
   // Counts cycles port 0 sinks, and cycles ports 0 and 1 disagree
   task automatic cnt;
      repeat (4) @(posedge clk);
      n0 = 0;
      nx = 0;
      repeat (512) begin
         @(posedge clk);
         n0 = n0 + int'(port_oe[0]);
         nx = nx + int'(port_oe[0] ^ port_oe[1]);
      end
   endtask

   task automatic t_reset;
      chk("mode", 10'(LPC_SHUTDOWN), 10'(seq_mode));
      chk("oe", 10'h000, port_oe);
      chk("inen", 10'h000, input_enable);
      chk("osc", 10'h000, 10'(osc_external));
      cfg(8'h00);
      host.rd(7'h20, v);
      chk("unmapped", 10'h000, 10'(v));
   endtask
   task automatic t_modes;
      host.wr(LPC_ADDR_CONFIG, 8'h22);
      cfg(8'h22);
      host.wr(LPC_ADDR_CONFIG, 8'h01);
      cfg(8'h01);
      host.wr(LPC_ADDR_CONFIG, 8'h00);
      cfg(8'h00);
      host.wr(LPC_ADDR_CONFIG, 8'h05);
      cfg(8'h05);
      evp(3);
      cfg(8'h01);
      host.wr(LPC_ADDR_CONFIG, 8'h19);
      cfg(8'h01);
      evp(0);
      cfg(8'h10);
      host.wr(LPC_ADDR_CONFIG, 8'h01);
      cfg(8'h01);
      evp(0);
      evp(1);
      cfg(8'h08);
      host.wr(LPC_ADDR_CONFIG, 8'h01);
      cfg(8'h01);
      evp(0);
      evp(1);
      evp(2);
      cfg(8'h00);
   endtask
   task automatic t_wake;
      host.wr(LPC_ADDR_CONFIG, 8'h02);
      cfg(8'h02);
      cs_wake <= 1'b1;
      repeat (3) @(posedge clk);
      cs_wake <= 1'b0;
      for (int i = 0; i < 8 && seq_mode !== 3'(LPC_RUN); i++) @(posedge clk);
      cfg(8'h03);
      host.wr(LPC_ADDR_CONFIG, 8'h80);
      @(posedge clk);
      chk("osc", 10'h001, 10'(osc_external));
      cfg(8'h80);
      host.wr(LPC_ADDR_CONFIG, 8'h00);
   endtask
   // Port outputs lag a write by two registers; look after they settle
   task automatic settle;
      @(posedge clk);
      #1;
   endtask
   task automatic t_ports;
      ext_level <= 10'h2a5;
      host.wr(LPC_ADDR_GRP_ALL, LPC_CODE_INPUT);
      settle();
      chk("inen", 10'h3ff, input_enable);
      host.rd(LPC_ADDR_IN_LOW, v);
      chk("in_low", 10'h0a5, 10'(v));
      host.rd(LPC_ADDR_IN_HIGH, v);
      chk("in_high", 10'h002, 10'(v));
      host.wr(LPC_ADDR_IN_LOW, 8'h00);
      host.wr(LPC_ADDR_IN_HIGH, 8'h00);
      host.rd(LPC_ADDR_IN_LOW, v);
      chk("in_low", 10'h0a5, 10'(v));
      host.wr(7'h02, LPC_CODE_LOW);
      settle();
      chk("oe", 10'h004, port_oe);
      chk("out", 10'h000, port_out);
      host.rd(LPC_ADDR_IN_LOW, v);
      chk("in_low", 10'h0a1, 10'(v));
      host.wr(LPC_ADDR_GRP_LOW, LPC_CODE_HIZ);
      host.wr(LPC_ADDR_GRP_MID, LPC_CODE_HIZ);
      settle();
      chk("inen", 10'h300, input_enable);
      host.wr(LPC_ADDR_GRP_HIGH, LPC_CODE_HIZ);
      settle();
      chk("inen", 10'h000, input_enable);
      for (int i = 0; i < 10; i++) begin
         host.wr(7'(i), LPC_CODE_INPUT);
         settle();
         chk("inen", 10'((11'h1 << (i + 1)) - 11'h1), input_enable);
      end
   endtask
   task automatic t_pwm;
      host.wr(LPC_ADDR_GRP_ALL, LPC_CODE_SINK);
      settle();
      chk("oe", 10'h000, port_oe);
      host.wr(LPC_ADDR_CONFIG, 8'h01);
      settle();
      chk("oe", 10'h3ff, port_oe);
      foreach (codes[k]) begin
         host.wr(LPC_ADDR_GRP_ALL, codes[k]);
         cnt();
         chk("duty", 10'(2 * int'(codes[k])), 10'(n0));
         chk("phase", 10'h000, 10'(nx));
      end
      // Half duty: ports 0 and 1 disagree for 64 of 256 counts when staggered
      host.wr(LPC_ADDR_GRP_ALL, 8'h80);
      host.wr(LPC_ADDR_CONFIG, 8'h20);
      host.wr(LPC_ADDR_CONFIG, 8'h21);
      cnt();
      chk("stagger", 10'd128, 10'(nx));
   endtask
   task automatic report_and_stop;
      $display("Checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      resetn = 1'b0;
      cs_wake = 1'b0;
      ev = 4'h0;
      pwm_tick = 1'b0;
      ext_level = 10'h3ff;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_modes();
      t_wake();
      t_ports();
      t_pwm();
      report_and_stop();
   end
endmodule
